/* core/tmr2_timer.sv */
// Second 16-bit timer/counter with capture, auto-reload and baud modes, APB slave.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// Functional notes
// RQ1 - Count register is 16 bits, split into low and high bytes.
// RQ2 - Five registers: count low/high, control, capture low/high.
// RQ3 - Counter-select bit picks machine cycles or external event edges.
// RQ4 - Run plus clock-select picks baud; else capture or reload; run off stops.
// RQ5 - Trigger falling edge with enable causing capture or reload sets external flag.
// RQ6 - External flag at one requests the timer interrupt when enabled; irq uses status bit 1, set with the flag and cleared by a status read.
// RQ7 - External flag is never cleared by hardware; software writes control.
// RQ8 - Receive clock-select routes this timer's overflow to serial receive clock.
// RQ9 - Receive clock-select zero routes timer 1 overflow to receive clock.
// RQ10 - Capture mode overflow sets overflow flag, which can interrupt.
// RQ11 - Capture mode trigger edge copies count bytes into capture bytes.
// RQ12 - Reload mode rollover sets flag, reloads; trigger edge also reloads.
// RQ13 - Transmit clock-select picks this timer or timer 1 overflow for transmit.
// RQ14 - Overflow flag sticky until software clears; not set in baud mode.
module tmr2_timer (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_trigger_pin,
    input  wire logic        event_pin,
    input  wire logic        timer1_overflow,
    output logic             serial_rx_clock,
    output logic             serial_tx_clock,
    output logic             irq
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] trig_sync;
    logic [2:0] evt_sync;
    logic       trig_level;
    logic       evt_level;
    // The trigger pin idles high, so the stages reset high and no false edge follows reset.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            trig_sync  <= 3'h7;
            trig_level <= 1'b1;
        end else begin
            trig_sync <= {trig_sync[1:0], external_trigger_pin};
            if (trig_sync[1] == trig_sync[2]) begin
                trig_level <= trig_sync[2];
            end
        end
    end

    // The event pin is filtered the same way before its falling edges are counted.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            evt_sync  <= 3'h7;
            evt_level <= 1'b1;
        end else begin
            evt_sync <= {evt_sync[1:0], event_pin};
            if (evt_sync[1] == evt_sync[2]) begin
                evt_level <= evt_sync[2];
            end
        end
    end
    // A filtered level only changes when two stages agree, so glitches are dropped.
    wire trig_fall = trig_level & ~trig_sync[2] & ~trig_sync[1];
    wire evt_fall  = evt_level & ~evt_sync[2] & ~evt_sync[1];

    // ****************************************
    // Registers and mode decode
    // ****************************************
    logic [7:0]  control;
    logic [7:0]  count_low_byte;
    logic [7:0]  count_high_byte;
    logic [7:0]  capture_low_byte;
    logic [7:0]  capture_high_byte;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [3:0]  prescale;

    wire overflow_flag           = control[tmr2_pkg::CTL_OVF];
    wire external_flag           = control[tmr2_pkg::CTL_EXF];
    wire receive_clock_select    = control[tmr2_pkg::CTL_RCLK];
    wire transmit_clock_select   = control[tmr2_pkg::CTL_TRANSMIT_CLOCK_SELECT];
    wire external_trigger_enable = control[tmr2_pkg::CTL_EXEN];
    wire run_bit                 = control[tmr2_pkg::CTL_RUN];
    wire counter_select          = control[tmr2_pkg::CTL_CSEL];
    wire capture_reload_select   = control[tmr2_pkg::CTL_CPRL];

    tmr2_pkg::tmr2_mode_t mode;
    assign mode = !run_bit ? tmr2_pkg::TMR2_OFF :                             // [RQ4]
        (receive_clock_select | transmit_clock_select) ? tmr2_pkg::TMR2_BAUD :
        capture_reload_select ? tmr2_pkg::TMR2_CAPTURE : tmr2_pkg::TMR2_RELOAD;

    wire machine_tick = (prescale == 4'(tmr2_pkg::MACHINE_DIV - 1));
    wire tick = counter_select ? evt_fall : machine_tick;                    // [RQ3]
    wire running = (mode != tmr2_pkg::TMR2_OFF);
    wire [15:0] count = {count_high_byte, count_low_byte};                   // [RQ1]
    wire rollover = running & tick & (count == tmr2_pkg::COUNT_MAX);
    wire baud_mode = (mode == tmr2_pkg::TMR2_BAUD);
    // The trigger pin is ignored while the timer clocks the serial port.
    wire trig_act = trig_fall & external_trigger_enable & running & ~baud_mode;
    wire do_capture = trig_act & (mode == tmr2_pkg::TMR2_CAPTURE);           // [RQ11]
    wire do_reload = (rollover & ~(mode == tmr2_pkg::TMR2_CAPTURE))         // [RQ12]
        | (trig_act & (mode == tmr2_pkg::TMR2_RELOAD));
    wire set_ovf = rollover & ~baud_mode;                                    // [RQ10] [RQ14]
    wire set_exf = trig_act;                                                 // [RQ5]
    wire [15:0] next_count = do_reload ? {capture_high_byte, capture_low_byte} :
        (running & tick) ? 16'(count + 16'h0001) : count;

    // ****************************************
    // APB decode
    // ****************************************
    wire wr_en = psel & penable & pwrite;
    wire rd_en = psel & penable & ~pwrite;
    wire sel_ctl  = (paddr == tmr2_pkg::ADDR_CONTROL);
    wire sel_cl   = (paddr == tmr2_pkg::ADDR_COUNT_LOW);
    wire sel_ch   = (paddr == tmr2_pkg::ADDR_COUNT_HIGH);
    wire sel_pl   = (paddr == tmr2_pkg::ADDR_CAPTURE_LOW);
    wire sel_ph   = (paddr == tmr2_pkg::ADDR_CAPTURE_HIGH);
    wire sel_st   = (paddr == tmr2_pkg::ADDR_IRQ_STATUS);
    wire sel_mk   = (paddr == tmr2_pkg::ADDR_IRQ_MASK);
    wire mapped   = sel_ctl | sel_cl | sel_ch | sel_pl | sel_ph | sel_st | sel_mk;
    wire [7:0] wbyte = pwdata[7:0];

    // Read data for one register word; unmapped words read as zero.
    function automatic logic [31:0] read_word(
        input logic [11:0] addr,
        input logic [7:0]  ctl,
        input logic [15:0] cnt,
        input logic [15:0] cap,
        input logic [1:0]  status,
        input logic [1:0]  mask
    );
        logic [31:0] word;
        word = 32'h0;
        case (addr)
            tmr2_pkg::ADDR_CONTROL:      word = {24'h0, ctl};
            tmr2_pkg::ADDR_COUNT_LOW:    word = {24'h0, cnt[7:0]};
            tmr2_pkg::ADDR_COUNT_HIGH:   word = {24'h0, cnt[15:8]};
            tmr2_pkg::ADDR_CAPTURE_LOW:  word = {24'h0, cap[7:0]};
            tmr2_pkg::ADDR_CAPTURE_HIGH: word = {24'h0, cap[15:8]};
            tmr2_pkg::ADDR_IRQ_STATUS:   word = {30'h0, status};
            tmr2_pkg::ADDR_IRQ_MASK:     word = {30'h0, mask};
            default:                     word = 32'h0;
        endcase
        return word;
    endfunction : read_word

    wire [31:0] next_rdata = read_word(paddr, control, count,                // [RQ2]
        {capture_high_byte, capture_low_byte}, irq_status, irq_mask);

    // Flags set by hardware win over a software write in the same cycle.
    wire [7:0] ctl_wr = (wr_en & sel_ctl) ? wbyte : control;
    wire [7:0] next_control = {ctl_wr[7] | set_ovf,                           // [RQ14]
                               ctl_wr[6] | set_exf,                           // [RQ7]
                               ctl_wr[5:0]};
    wire [1:0] events = {set_exf, set_ovf};
    wire [1:0] next_status = ((rd_en & sel_st) ? 2'h0 : irq_status) | events;

    // ****************************************
    // Prescaler
    // ****************************************
    // The prescaler runs freely, so the first internal tick after a start may come early.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prescale <= 4'h0;
        end else begin
            prescale <= machine_tick ? 4'h0 : 4'(prescale + 4'h1);
        end
    end

    // ****************************************
    // Control and counter registers
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            control <= tmr2_pkg::CTL_RESET;
        end else begin
            control <= next_control;
        end
    end

    // A write to a count byte overrides counting in the same cycle.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count_low_byte <= tmr2_pkg::BYTE_RESET;
        end else begin
            count_low_byte <= (wr_en & sel_cl) ? wbyte : next_count[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count_high_byte <= tmr2_pkg::BYTE_RESET;
        end else begin
            count_high_byte <= (wr_en & sel_ch) ? wbyte : next_count[15:8];
        end
    end

    // ****************************************
    // Capture registers
    // ****************************************
    // A trigger edge cannot be repeated, so a capture wins over a software write.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            capture_low_byte <= tmr2_pkg::BYTE_RESET;
        end else if (do_capture) begin
            capture_low_byte <= count_low_byte;
        end else if (wr_en & sel_pl) begin
            capture_low_byte <= wbyte;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            capture_high_byte <= tmr2_pkg::BYTE_RESET;
        end else if (do_capture) begin
            capture_high_byte <= count_high_byte;
        end else if (wr_en & sel_ph) begin
            capture_high_byte <= wbyte;
        end
    end

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_status <= tmr2_pkg::IRQ_RESET;
        end else begin
            irq_status <= next_status;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask <= tmr2_pkg::IRQ_RESET;
        end else if (wr_en & sel_mk) begin
            irq_mask <= pwdata[1:0];
        end
    end

    // The line is registered, so it never glitches while status and mask change together.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & irq_mask);                                // [RQ6]
        end
    end

    // ****************************************
    // Bus responses
    // ****************************************
    // Zero wait states: every access phase ends in the cycle after its setup.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & ~penable & ~mapped;
        end
    end

    // Read data stands only in the access cycle and reads zero otherwise.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0;
        end else begin
            prdata <= (psel & ~penable & ~pwrite) ? next_rdata : 32'h0;
        end
    end

    // ****************************************
    // Serial clock routing
    // ****************************************
    // Overflow pulses are sent even when software ignores the flag.
    wire t2_pulse = rollover;
    // Both lines lag their source by one cycle, so receive and transmit stay aligned.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            serial_rx_clock <= 1'b0;
        end else begin
            serial_rx_clock <= receive_clock_select ? t2_pulse : timer1_overflow;  // [RQ8] [RQ9]
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            serial_tx_clock <= 1'b0;
        end else begin
            serial_tx_clock <= transmit_clock_select ? t2_pulse : timer1_overflow; // [RQ13]
        end
    end
endmodule : tmr2_timer

/* pkg/tmr2_pkg.sv */
// Package with register map, field positions and reset values of the second timer.
package tmr2_pkg;
    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [11:0] ADDR_CONTROL     = 12'h000;
    localparam logic [11:0] ADDR_COUNT_LOW   = 12'h004;
    localparam logic [11:0] ADDR_COUNT_HIGH  = 12'h008;
    localparam logic [11:0] ADDR_CAPTURE_LOW = 12'h00c;
    localparam logic [11:0] ADDR_CAPTURE_HIGH= 12'h010;
    localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h014;
    localparam logic [11:0] ADDR_IRQ_MASK    = 12'h018;
    // ****************************************
    // Control register fields
    // ****************************************
    localparam int CTL_OVF   = 7;
    localparam int CTL_EXF   = 6;
    localparam int CTL_RCLK  = 5;
    localparam int CTL_TRANSMIT_CLOCK_SELECT  = 4;
    localparam int CTL_EXEN  = 3;
    localparam int CTL_RUN   = 2;
    localparam int CTL_CSEL  = 1;
    localparam int CTL_CPRL  = 0;
    localparam logic [7:0] CTL_RESET  = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // ****************************************
    // Interrupt status fields
    // ****************************************
    localparam int IRQ_OVF   = 0;
    localparam int IRQ_EXT   = 1;
    localparam int IRQ_W     = 2;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // Internal timer ticks once per machine cycle of twelve clocks.
    localparam int MACHINE_DIV = 12;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    typedef enum logic [1:0] {
        TMR2_OFF     = 2'b00,
        TMR2_RELOAD  = 2'b01,
        TMR2_CAPTURE = 2'b11,
        TMR2_BAUD    = 2'b10
    } tmr2_mode_t;
endpackage : tmr2_pkg

/* verification/tb.sv */
// Self-checking testbench for the second timer.
`timescale 1ns/1ps
module tb;
    logic        clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, err, irq;
    logic        external_trigger_pin, event_pin, timer1_overflow;
    logic        serial_rx_clock, serial_tx_clock;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [7:0]  a, b;
    int          fails = 0, checked = 0, cycles = 0, seed;
    // Index 0 control, 1-2 count, 3-4 capture, 5 status, 6 mask, 7 unmapped.
    logic [11:0] ra [8] = '{tmr2_pkg::ADDR_CONTROL, tmr2_pkg::ADDR_COUNT_LOW,
        tmr2_pkg::ADDR_COUNT_HIGH, tmr2_pkg::ADDR_CAPTURE_LOW, tmr2_pkg::ADDR_CAPTURE_HIGH,
        tmr2_pkg::ADDR_IRQ_STATUS, tmr2_pkg::ADDR_IRQ_MASK, 12'h01c};
    tmr2_timer tmr2_timer_inst (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .external_trigger_pin, .event_pin, .timer1_overflow,
        .serial_rx_clock, .serial_tx_clock, .irq);
    tmr2_far_end tmr2_far_end_inst (.clk_sys, .serial_rx_clock, .serial_tx_clock,
        .external_trigger_pin, .event_pin, .timer1_overflow);
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            $display("[FAIL] %0t timeout", $time);
            summarize();
        end
    end
    function automatic logic [31:0] exp_ticks(input logic sel);
        return sel ? 32'h0 : 32'h3;
    endfunction : exp_ticks
    task automatic summarize();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic apb(input logic wr, input int idx, input logic [7:0] wd);
        @(posedge clk_sys);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, ra[idx], 24'h0, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic rd(input int idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        cmp(rdata, {24'h0, exp});
    endtask : rd
    initial begin
        seed = 32'h0f0d;
        {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(i, 8'h00);
        cmp(err, 1'b1);
        for (int i = 0; i < 4; i++) begin
            {a, b} = 16'($random(seed));
            for (int j = 1; j < 5; j++) apb(1'b1, j, j[0] ? a : b);
            repeat (30) @(posedge clk_sys);
            for (int j = 1; j < 5; j++) rd(j, j[0] ? a : b);
        end
        apb(1'b1, 6, 8'h03);
        apb(1'b1, 3, 8'h00);
        apb(1'b1, 2, 8'hff);
        apb(1'b1, 1, 8'hf0);
        apb(1'b1, 0, 8'h04);
        repeat (300) @(posedge clk_sys);
        cmp(irq, 1'b1);
        rd(2, b);
        rd(0, 8'h84);
        rd(5, 8'h01);
        repeat (3) @(posedge clk_sys);
        cmp(irq, 1'b0);
        a = {1'b0, 7'($random(seed))};
        apb(1'b1, 6, 8'h00);
        apb(1'b1, 0, 8'h00);
        apb(1'b1, 1, a);
        apb(1'b1, 0, 8'h0f);
        tmr2_far_end_inst.fall_edge(1'b0);
        rd(3, a);
        rd(4, b);
        rd(0, 8'h4f);
        cmp(irq, 1'b0);
        apb(1'b1, 6, 8'h02);
        repeat (3) @(posedge clk_sys);
        cmp(irq, 1'b1);
        rd(5, 8'h02);
        rd(0, 8'h4f);
        for (int i = 0; i < 5; i++) tmr2_far_end_inst.fall_edge(1'b1);
        rd(1, a + 8'h05);
        apb(1'b1, 2, 8'h00);
        apb(1'b1, 0, 8'h0c);
        tmr2_far_end_inst.fall_edge(1'b0);
        rd(2, b);
        rd(0, 8'h4c);
        apb(1'b1, 0, 8'h00);
        for (int j = 1; j < 5; j++) apb(1'b1, j, j[0] ? 8'hf0 : 8'hff);
        apb(1'b1, 0, 8'h3c);
        tmr2_far_end_inst.clear_counts();
        repeat (1000) @(posedge clk_sys);
        tmr2_far_end_inst.fall_edge(1'b0);
        rd(0, 8'h3c);
        cmp(tmr2_far_end_inst.rx_count >= 4, 1'b1);
        cmp(tmr2_far_end_inst.tx_count >= 4, 1'b1);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, 0, 8'(s << 4));
            tmr2_far_end_inst.clear_counts();
            repeat (3) tmr2_far_end_inst.timer1_tick();
            repeat (3) @(posedge clk_sys);
            cmp(tmr2_far_end_inst.rx_count, exp_ticks(s[1]));
            cmp(tmr2_far_end_inst.tx_count, exp_ticks(s[0]));
        end
        summarize();
    end
endmodule : tb
bind tmr2_timer tmr2_timer_assertions tmr2_timer_assertions_inst (.clk_sys, .arst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .external_trigger_pin,
    .event_pin, .timer1_overflow, .serial_rx_clock, .serial_tx_clock, .irq);

/* verification/tmr2_far_end.sv */
// Far-end model: trigger and event pins, timer 1 overflow, serial clock counters.
`timescale 1ns/1ps
module tmr2_far_end (
    input  wire logic clk_sys,
    input  wire logic serial_rx_clock,
    input  wire logic serial_tx_clock,
    output logic      external_trigger_pin,
    output logic      event_pin,
    output logic      timer1_overflow
);
    int   rx_count = 0;
    int   tx_count = 0;
    logic clear = 1'b0;
    initial {external_trigger_pin, event_pin, timer1_overflow} = 3'b110;
    // The serial port takes one bit-clock tick for each pulse on either line.
    always @(posedge clk_sys) begin
        rx_count <= clear ? 0 : rx_count + int'(serial_rx_clock === 1'b1);
        tx_count <= clear ? 0 : tx_count + int'(serial_tx_clock === 1'b1);
    end
    task automatic clear_counts();
        @(posedge clk_sys);
        clear <= 1'b1;
        @(posedge clk_sys);
        clear <= 1'b0;
    endtask : clear_counts
    // Pins idle high as pulled-up port pins do; a low of six cycles outlasts the synchroniser.
    task automatic fall_edge(input logic on_event);
        @(posedge clk_sys);
        if (on_event) event_pin <= 1'b0;
        else external_trigger_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        {event_pin, external_trigger_pin} <= 2'b11;
        repeat (6) @(posedge clk_sys);
    endtask : fall_edge
    task automatic timer1_tick();
        @(posedge clk_sys);
        timer1_overflow <= 1'b1;
        @(posedge clk_sys);
        timer1_overflow <= 1'b0;
    endtask : timer1_tick
endmodule : tmr2_far_end

/* verification/tmr2_timer_assertions.sv */
// Port-level assertions for the second timer.
`timescale 1ns/1ps
module tmr2_timer_assertions (
    input wire logic        clk_sys, arst_n, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic        pready, pslverr, external_trigger_pin, event_pin,
    input wire logic        timer1_overflow, serial_rx_clock, serial_tx_clock, irq
);
    logic [1:0] clk_sel;
    // Mirror of the clock-select bits, so that routing is judged at the pins alone.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) clk_sel <= 2'b00;
        else if (psel && penable && pwrite && paddr == tmr2_pkg::ADDR_CONTROL)
            clk_sel <= pwdata[tmr2_pkg::CTL_RCLK -: 2];
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    setup_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    unmapped_err_a: assert property (psel && !penable && paddr > tmr2_pkg::ADDR_IRQ_MASK
        |=> pslverr) else $error("no slave error");
    read_width_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("wide");
    idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("stale data");
    rx_route_a: assert property (!clk_sel[1] && timer1_overflow |=> serial_rx_clock)
        else $error("rx clock lost");
    tx_route_a: assert property (!clk_sel[0] && timer1_overflow |=> serial_tx_clock)
        else $error("tx clock lost");
    irq_drop_a: assert property ($fell(irq) |-> $past(penable)) else $error("irq drop");
    cover property (pslverr);
    cover property ($fell(irq));
    cover property (clk_sel[1] && serial_rx_clock);
endmodule : tmr2_timer_assertions
